//--- ops_stage_top.sv
// Overpower stage: pickup, timing, blocking, events, records.
// Assumes same-clock measurements; block_in from a pin.
`timescale 1ns/1ps
`include "ops_defines.svh"
module ops_stage_top #(
  parameter int unsigned CYCLE_CLKS = `OPS_CYCLE_CLKS
) (
  input logic clk,
  input logic sys_rst,
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [31:0] reg_rdata,
  input logic [31:0] measured_active_power,
  input logic [15:0] phase_current_l1,
  input logic [15:0] phase_current_l2,
  input logic [15:0] phase_current_l3,
  input logic [15:0] voltage_u1,
  input logic [15:0] voltage_u2,
  input logic [15:0] voltage_u3,
  input logic [15:0] voltage_u4,
  input logic [2:0] active_setting_group,
  input logic block_in,
  input logic stage_forcing_enable,
  input logic [47:0] rtc_timestamp,
  output logic start_out,
  output logic trip_out,
  output logic blocked_out,
  output logic [1:0] condition,
  output logic event_valid,
  output logic [2:0] event_code,
  output logic [47:0] event_stamp
);

  // Value times percentage, no overflow
  function automatic logic [39:0] ops_scale(input logic [31:0] val, input logic [7:0] pct);
    ops_scale = 40'(val) * 40'(pct);
  endfunction

  // Word index of an address within an area
  function automatic logic [7:0] ops_word_idx(input logic [7:0] addr, input logic [7:0] base);
    ops_word_idx = (addr - base) >> `OPS_WORD_SHIFT;
  endfunction

  logic tick;
  logic blk_meta_q;
  logic blk_sync_q;
  logic blk_q;
  logic pick_q;
  logic pick_d;
  logic over;
  logic under;
  logic [31:0] thr;
  logic [31:0] thr_safe;
  logic [19:0] op_delay;
  logic [19:0] rel_delay;
  logic [31:0] grp_pickup_q [`OPS_GROUPS];
  logic [19:0] grp_op_delay_q [`OPS_GROUPS];
  logic [19:0] grp_rel_delay_q [`OPS_GROUPS];
  logic [31:0] hist_q [`OPS_HIST_DEPTH];
  logic [15:0] meas_q [`OPS_MEAS_CH];
  logic [15:0] meas_in [`OPS_MEAS_CH];
  logic [31:0] ratio_q;
  ops_pkg::ops_cond_e state_q;
  ops_pkg::ops_cond_e state_d;
  ops_pkg::ops_cond_e forced_sel_q;
  logic [19:0] op_cnt_q;
  logic [19:0] op_cnt_d;
  logic [19:0] rel_cnt_q;
  logic [19:0] rel_cnt_d;
  logic [19:0] remain_q;
  logic [19:0] expected_q;
  logic start_prev_q;
  logic trip_prev_q;
  logic blk_prev_q;
  logic [5:0] edge_v;
  logic [5:0] evmask_q;
  logic [5:0] pend_q;
  logic [5:0] grant;
  logic [2:0] grant_code;
  logic [31:0] cnt_q [`OPS_NUM_CNT];
  logic [2:0] cnt_inc;
  logic [2:0] cnt_clr;
  logic [3:0] flt_sel_q;
  logic rec_wr;
  logic [2:0] rec_event;
  logic [47:0] rd_stamp;
  logic [2:0] rd_event;
  logic [31:0] rd_pre;
  logic [31:0] rd_fault;
  logic [31:0] rd_prefault;
  logic [19:0] rd_remain;
  logic [2:0] rd_group;
  logic [3:0] rec_count;
  logic [7:0] grp_off;
  logic [7:0] meas_idx;
  logic [31:0] rd_mux;

  // Processing cycle time base
  ops_cycle_tick #(
    .CYCLE_CLKS(CYCLE_CLKS)
  ) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(tick)
  );

  // Two-stage synchroniser for the blocking input
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      blk_meta_q <= 1'b0;
      blk_sync_q <= 1'b0;
    end else begin
      blk_meta_q <= block_in;
      blk_sync_q <= blk_meta_q;
    end
  end

  // Settings of the active group, read live each cycle
  assign thr = grp_pickup_q[active_setting_group];
  assign op_delay = grp_op_delay_q[active_setting_group];
  assign rel_delay = grp_rel_delay_q[active_setting_group];
  assign thr_safe = (thr == 32'h0000_0000) ? `OPS_MIN_PICKUP : thr;

  // Pickup with built-in reset hysteresis
  assign over = ops_scale(measured_active_power, `OPS_FULL_PCT) > ops_scale(thr, `OPS_FULL_PCT);
  assign under = ops_scale(measured_active_power, `OPS_FULL_PCT) < ops_scale(thr, `OPS_RESET_PCT);
  assign pick_d = pick_q ? ~under : over;

  // Once-per-cycle samples: pickup, blocking, ratio
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pick_q <= 1'b0;
      blk_q <= 1'b0;
      ratio_q <= 32'h0000_0000;
    end else if (tick) begin
      pick_q <= pick_d;
      blk_q <= blk_sync_q;
      ratio_q <= 32'(ops_scale(measured_active_power, `OPS_FULL_PCT) / 40'(thr_safe));
    end
  end

  // Power history, newest at index 0
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `OPS_HIST_DEPTH; i++) begin
        hist_q[i] <= 32'h0000_0000;
      end
    end else if (tick) begin
      hist_q[0] <= measured_active_power;
      for (int i = 1; i < `OPS_HIST_DEPTH; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
    end
  end

  // Measurements latched per cycle
  assign meas_in[0] = phase_current_l1;
  assign meas_in[1] = phase_current_l2;
  assign meas_in[2] = phase_current_l3;
  assign meas_in[3] = voltage_u1;
  assign meas_in[4] = voltage_u2;
  assign meas_in[5] = voltage_u3;
  assign meas_in[6] = voltage_u4;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `OPS_MEAS_CH; i++) begin
        meas_q[i] <= 16'h0000;
      end
    end else if (tick) begin
      for (int i = 0; i < `OPS_MEAS_CH; i++) begin
        meas_q[i] <= meas_in[i];
      end
    end
  end

  // Stage state machine, next state
  always_comb begin
    state_d = state_q;
    op_cnt_d = op_cnt_q;
    rel_cnt_d = rel_cnt_q;
    unique case (state_q)
      ops_pkg::OPS_NORMAL: begin
        op_cnt_d = 20'h0_0000;
        rel_cnt_d = 20'h0_0000;
        if (pick_d && blk_sync_q) begin
          state_d = ops_pkg::OPS_BLOCKED;
        end else if (pick_d) begin
          state_d = ops_pkg::OPS_START;
        end
      end
      ops_pkg::OPS_START: begin
        if (pick_d && !blk_sync_q) begin
          rel_cnt_d = 20'h0_0000;
          if (op_cnt_q + 20'h0_0001 >= op_delay) begin
            state_d = ops_pkg::OPS_TRIP;
          end else begin
            op_cnt_d = op_cnt_q + 20'h0_0001;
          end
        end else if (rel_cnt_q + 20'h0_0001 >= rel_delay) begin
          state_d = ops_pkg::OPS_NORMAL;
        end else begin
          rel_cnt_d = rel_cnt_q + 20'h0_0001;
        end
      end
      ops_pkg::OPS_TRIP: begin
        if (pick_d && !blk_sync_q) begin
          rel_cnt_d = 20'h0_0000;
        end else if (rel_cnt_q + 20'h0_0001 >= rel_delay) begin
          state_d = ops_pkg::OPS_NORMAL;
        end else begin
          rel_cnt_d = rel_cnt_q + 20'h0_0001;
        end
      end
      ops_pkg::OPS_BLOCKED: begin
        if (!(pick_d && blk_sync_q)) begin
          state_d = ops_pkg::OPS_NORMAL;
        end
      end
    endcase
  end

  // Stage state and stage outputs, advanced once per cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ops_pkg::OPS_NORMAL;
      op_cnt_q <= 20'h0_0000;
      rel_cnt_q <= 20'h0_0000;
      start_out <= 1'b0;
      trip_out <= 1'b0;
      blocked_out <= 1'b0;
    end else if (tick) begin
      state_q <= state_d;
      op_cnt_q <= op_cnt_d;
      rel_cnt_q <= rel_cnt_d;
      start_out <= (state_d == ops_pkg::OPS_TRIP) || (state_d == ops_pkg::OPS_START && !blk_sync_q);
      trip_out <= (state_d == ops_pkg::OPS_TRIP);
      blocked_out <= (state_d == ops_pkg::OPS_BLOCKED);
    end
  end

  // Expected operating time and countdown, in 5 ms steps
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      expected_q <= 20'h0_0000;
      remain_q <= 20'h0_0000;
    end else if (tick) begin
      expected_q <= op_delay;
      remain_q <= (state_d == ops_pkg::OPS_START) ? op_delay - op_cnt_d : 20'h0_0000;
    end
  end

  // Reported condition, forcing overrides
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      condition <= ops_pkg::OPS_NORMAL;
    end else begin
      condition <= stage_forcing_enable ? forced_sel_q : state_q;
    end
  end

  // Output edge detection
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      start_prev_q <= 1'b0;
      trip_prev_q <= 1'b0;
      blk_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_out;
      trip_prev_q <= trip_out;
      blk_prev_q <= blocked_out;
    end
  end
  assign edge_v[ops_pkg::OPS_EV_START_ON] = start_out & ~start_prev_q;
  assign edge_v[ops_pkg::OPS_EV_START_OFF] = ~start_out & start_prev_q;
  assign edge_v[ops_pkg::OPS_EV_TRIP_ON] = trip_out & ~trip_prev_q;
  assign edge_v[ops_pkg::OPS_EV_TRIP_OFF] = ~trip_out & trip_prev_q;
  assign edge_v[ops_pkg::OPS_EV_BLK_ON] = blocked_out & ~blk_prev_q;
  assign edge_v[ops_pkg::OPS_EV_BLK_OFF] = ~blocked_out & blk_prev_q;

  // Lowest pending event goes out first
  always_comb begin
    grant = 6'h00;
    grant_code = 3'h0;
    for (int i = 5; i >= 0; i--) begin
      if (pend_q[i]) begin
        grant = 6'h01 << i;
        grant_code = 3'(i);
      end
    end
  end

  // Pending events and the time-stamped event port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_q <= 6'h00;
      event_valid <= 1'b0;
      event_code <= 3'h0;
      event_stamp <= 48'h0000_0000_0000;
    end else begin
      pend_q <= (pend_q & ~grant) | (edge_v & evmask_q);
      event_valid <= |pend_q;
      if (|pend_q) begin
        event_code <= grant_code;
        event_stamp <= rtc_timestamp;
      end
    end
  end

  // Counters, clear wins but keeps a same-cycle increment as 1
  assign cnt_inc = {edge_v[ops_pkg::OPS_EV_BLK_ON], edge_v[ops_pkg::OPS_EV_TRIP_ON], edge_v[ops_pkg::OPS_EV_START_ON]};
  assign cnt_clr = (reg_wr && reg_addr == `OPS_A_CNT_CLR) ? reg_wdata[2:0] : 3'h0;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `OPS_NUM_CNT; i++) begin
        cnt_q[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < `OPS_NUM_CNT; i++) begin
        if (cnt_clr[i]) begin
          cnt_q[i] <= {31'h0000_0000, cnt_inc[i]};
        end else if (cnt_inc[i]) begin
          cnt_q[i] <= cnt_q[i] + 32'h0000_0001;
        end
      end
    end
  end

  // One fault record per clock with any activation
  assign rec_wr = |cnt_inc;
  assign rec_event = cnt_inc[0] ? ops_pkg::OPS_EV_START_ON :
                     cnt_inc[1] ? ops_pkg::OPS_EV_TRIP_ON : ops_pkg::OPS_EV_BLK_ON;
  ops_fault_ring u_ring (
    .clk(clk),
    .sys_rst(sys_rst),
    .rec_wr(rec_wr),
    .rec_stamp(rtc_timestamp),
    .rec_event(rec_event),
    .rec_pre(hist_q[`OPS_PRE_TRIG_IDX]),
    .rec_fault(hist_q[0]),
    .rec_prefault(hist_q[`OPS_PRE_FAULT_IDX]),
    .rec_remain(remain_q),
    .rec_group(active_setting_group),
    .rd_age(flt_sel_q),
    .rd_stamp(rd_stamp),
    .rd_event(rd_event),
    .rd_pre(rd_pre),
    .rd_fault(rd_fault),
    .rd_prefault(rd_prefault),
    .rd_remain(rd_remain),
    .rd_group(rd_group),
    .rec_count(rec_count)
  );

  // Software-written control registers
  assign grp_off = reg_addr - `OPS_A_GRP_BASE;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      forced_sel_q <= ops_pkg::OPS_NORMAL;
      evmask_q <= `OPS_EVMASK_DEFAULT;
      flt_sel_q <= 4'h0;
    end else if (reg_wr) begin
      if (reg_addr == `OPS_A_CTRL) begin
        forced_sel_q <= ops_pkg::ops_cond_e'(reg_wdata[`OPS_FORCE_FLD]);
      end
      if (reg_addr == `OPS_A_EVMASK) begin
        evmask_q <= reg_wdata[5:0];
      end
      if (reg_addr == `OPS_A_FLT_SEL) begin
        flt_sel_q <= reg_wdata[3:0];
      end
    end
  end

  // Setting group tables
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int g = 0; g < `OPS_GROUPS; g++) begin
        grp_pickup_q[g] <= `OPS_PICKUP_DEFAULT;
        grp_op_delay_q[g] <= `OPS_OP_DELAY_DEFAULT;
        grp_rel_delay_q[g] <= `OPS_REL_DELAY_DEFAULT;
      end
    end else if (reg_wr && reg_addr >= `OPS_A_GRP_BASE) begin
      unique case (grp_off[`OPS_GRP_FLD])
        `OPS_FLD_PICKUP: grp_pickup_q[grp_off[`OPS_GRP_SEL]] <= reg_wdata;
        `OPS_FLD_OP_DELAY: grp_op_delay_q[grp_off[`OPS_GRP_SEL]] <= reg_wdata[19:0];
        `OPS_FLD_REL_DELAY: grp_rel_delay_q[grp_off[`OPS_GRP_SEL]] <= reg_wdata[19:0];
        default: begin
        end
      endcase
    end
  end

  // Read decode
  assign meas_idx = ops_word_idx(reg_addr, `OPS_A_MEAS_BASE);
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr >= `OPS_A_GRP_BASE) begin
      unique case (grp_off[`OPS_GRP_FLD])
        `OPS_FLD_PICKUP: rd_mux = grp_pickup_q[grp_off[`OPS_GRP_SEL]];
        `OPS_FLD_OP_DELAY: rd_mux = {12'h000, grp_op_delay_q[grp_off[`OPS_GRP_SEL]]};
        `OPS_FLD_REL_DELAY: rd_mux = {12'h000, grp_rel_delay_q[grp_off[`OPS_GRP_SEL]]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end else if (reg_addr >= `OPS_A_MEAS_BASE) begin
      if (meas_idx < 8'(`OPS_MEAS_CH)) begin
        rd_mux = {16'h0000, meas_q[meas_idx[2:0]]};
      end
    end else begin
      case (reg_addr)
        `OPS_A_CTRL: rd_mux = {30'h0000_0000, forced_sel_q};
        `OPS_A_EVMASK: rd_mux = {26'h000_0000, evmask_q};
        `OPS_A_STATUS: rd_mux = {25'h000_0000, pick_q, blk_q, blocked_out, trip_out, start_out, condition};
        `OPS_A_RATIO: rd_mux = ratio_q;
        `OPS_A_EXP_TIME: rd_mux = {12'h000, expected_q};
        `OPS_A_REM_TIME: rd_mux = {12'h000, remain_q};
        `OPS_A_CNT_BASE: rd_mux = cnt_q[0];
        `OPS_A_CNT_BASE + 8'h04: rd_mux = cnt_q[1];
        `OPS_A_CNT_BASE + 8'h08: rd_mux = cnt_q[2];
        `OPS_A_FLT_SEL: rd_mux = {28'h000_0000, flt_sel_q};
        `OPS_A_FLT_COUNT: rd_mux = {28'h000_0000, rec_count};
        `OPS_A_FLT_STAMP_LO: rd_mux = rd_stamp[`OPS_STAMP_LO];
        `OPS_A_FLT_STAMP_HI: rd_mux = {16'h0000, rd_stamp[`OPS_STAMP_HI]};
        `OPS_A_FLT_EVENT: rd_mux = {29'h0000_0000, rd_event};
        `OPS_A_FLT_PRE: rd_mux = rd_pre;
        `OPS_A_FLT_FAULT: rd_mux = rd_fault;
        `OPS_A_FLT_PREFAULT: rd_mux = rd_prefault;
        `OPS_A_FLT_REMAIN: rd_mux = {12'h000, rd_remain};
        `OPS_A_FLT_GROUP: rd_mux = {29'h0000_0000, rd_group};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Read data, one cycle after strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

endmodule

//--- ops_defines.svh
// Constants of the overpower stage.
// Assumes a 20 MHz clock, 5 ms processing cycle.
// Overview of operation
// - Pick up when power exceeds threshold
// - Release below 97 percent of threshold
// - Expose live power to threshold ratio
// - Settings follow group, change while running
// - Sample blocking input once per cycle
// - Unblocked pickup asserts start, starts timing
// - Blocked pickup asserts blocked, no trip
// - Late blocking clears start, runs release
// - Trip and release are definite time
// - Expose expected and remaining time, 5 ms
// - Report condition: normal, start, trip, blocked
// - Six events on output edges, time stamped
// - Per-event mask gates main event buffer
// - Clearable start, trip, blocked counters
// - Exactly one stage instance
// - Ring of twelve stamped fault records
// - Record powers, remaining time, setting group
// - Start, trip, blocked available as outputs
// - Take three currents, four voltages inputs
// - Forcing overrides reported condition, default normal
`ifndef OPS_DEFINES_SVH
`define OPS_DEFINES_SVH

// Timing
`define OPS_CLK_PERIOD_NS 50
`define OPS_NS_PER_MS 1000000
`define OPS_CYCLE_MS 5
`define OPS_CYCLE_CLKS ((`OPS_CYCLE_MS * `OPS_NS_PER_MS) / `OPS_CLK_PERIOD_NS)
`define OPS_PRE_TRIG_MS 20
`define OPS_PRE_FAULT_MS 200
`define OPS_PRE_TRIG_IDX (`OPS_PRE_TRIG_MS / `OPS_CYCLE_MS)
`define OPS_PRE_FAULT_IDX (`OPS_PRE_FAULT_MS / `OPS_CYCLE_MS)
`define OPS_HIST_DEPTH (`OPS_PRE_FAULT_IDX + 1)

// Pickup arithmetic
`define OPS_FULL_PCT 8'h64
`define OPS_RESET_PCT 8'h61
`define OPS_MIN_PICKUP 32'h0000_0001

// Sizes
`define OPS_RING_DEPTH 12
`define OPS_GROUPS 8
`define OPS_MEAS_CH 7
`define OPS_NUM_CNT 3

// Reset values
`define OPS_PICKUP_DEFAULT 32'h0000_2710
`define OPS_OP_DELAY_DEFAULT 20'h0_0014
`define OPS_REL_DELAY_DEFAULT 20'h0_0000
`define OPS_EVMASK_DEFAULT 6'h3F

// Register map, byte addresses
`define OPS_WORD_SHIFT 2
`define OPS_A_CTRL 8'h00
`define OPS_A_CNT_CLR 8'h04
`define OPS_A_EVMASK 8'h08
`define OPS_A_STATUS 8'h0C
`define OPS_A_RATIO 8'h10
`define OPS_A_EXP_TIME 8'h14
`define OPS_A_REM_TIME 8'h18
`define OPS_A_CNT_BASE 8'h1C
`define OPS_A_FLT_SEL 8'h28
`define OPS_A_FLT_COUNT 8'h2C
`define OPS_A_FLT_STAMP_LO 8'h30
`define OPS_A_FLT_STAMP_HI 8'h34
`define OPS_A_FLT_EVENT 8'h38
`define OPS_A_FLT_PRE 8'h3C
`define OPS_A_FLT_FAULT 8'h40
`define OPS_A_FLT_PREFAULT 8'h44
`define OPS_A_FLT_REMAIN 8'h48
`define OPS_A_FLT_GROUP 8'h4C
`define OPS_A_MEAS_BASE 8'h60
`define OPS_A_GRP_BASE 8'h80
`define OPS_GRP_SEL 6:4
`define OPS_GRP_FLD 3:2
`define OPS_FLD_PICKUP 2'h0
`define OPS_FLD_OP_DELAY 2'h1
`define OPS_FLD_REL_DELAY 2'h2

// Field positions
`define OPS_FORCE_FLD 1:0
`define OPS_STAMP_LO 31:0
`define OPS_STAMP_HI 47:32

`endif

//--- ops_pkg.sv
// Types of the overpower stage.
// Assumes nothing beyond a SystemVerilog compiler.
package ops_pkg;

  // Reported stage condition
  typedef enum logic [1:0] {
    OPS_NORMAL  = 2'h0,
    OPS_START   = 2'h1,
    OPS_TRIP    = 2'h2,
    OPS_BLOCKED = 2'h3
  } ops_cond_e;

  // Event codes, also bit positions of the event mask
  typedef enum logic [2:0] {
    OPS_EV_START_ON  = 3'h0,
    OPS_EV_START_OFF = 3'h1,
    OPS_EV_TRIP_ON   = 3'h2,
    OPS_EV_TRIP_OFF  = 3'h3,
    OPS_EV_BLK_ON    = 3'h4,
    OPS_EV_BLK_OFF   = 3'h5
  } ops_event_e;

endpackage

//--- ops_cycle_tick.sv
// Cycle time base: pulse every CYCLE_CLKS clocks.
// Assumes one clock, synchronous reset.
`timescale 1ns/1ps
`include "ops_defines.svh"
module ops_cycle_tick #(
  parameter int unsigned CYCLE_CLKS = `OPS_CYCLE_CLKS
) (
  input logic clk,
  input logic sys_rst,
  output logic tick
);

  localparam int unsigned W = $clog2(CYCLE_CLKS);
  localparam logic [W-1:0] LAST = W'(CYCLE_CLKS - 1);

  logic [W-1:0] cnt_q;

  // Divider and pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + W'(1);
      tick <= 1'b0;
    end
  end

endmodule

//--- ops_fault_ring.sv
// Ring of recent fault records, oldest overwritten.
// Assumes one write per clock; read by age, 0 newest.
`timescale 1ns/1ps
`include "ops_defines.svh"
module ops_fault_ring (
  input logic clk,
  input logic sys_rst,
  input logic rec_wr,
  input logic [47:0] rec_stamp,
  input logic [2:0] rec_event,
  input logic [31:0] rec_pre,
  input logic [31:0] rec_fault,
  input logic [31:0] rec_prefault,
  input logic [19:0] rec_remain,
  input logic [2:0] rec_group,
  input logic [3:0] rd_age,
  output logic [47:0] rd_stamp,
  output logic [2:0] rd_event,
  output logic [31:0] rd_pre,
  output logic [31:0] rd_fault,
  output logic [31:0] rd_prefault,
  output logic [19:0] rd_remain,
  output logic [2:0] rd_group,
  output logic [3:0] rec_count
);

  localparam logic [4:0] DEPTH = 5'(`OPS_RING_DEPTH);

  logic [47:0] stamp_m [`OPS_RING_DEPTH];
  logic [2:0] event_m [`OPS_RING_DEPTH];
  logic [31:0] pre_m [`OPS_RING_DEPTH];
  logic [31:0] fault_m [`OPS_RING_DEPTH];
  logic [31:0] prefault_m [`OPS_RING_DEPTH];
  logic [19:0] remain_m [`OPS_RING_DEPTH];
  logic [2:0] group_m [`OPS_RING_DEPTH];
  logic [3:0] wp_q;
  logic [3:0] slot;

  // Slot of the record of a given age behind the write pointer
  function automatic logic [3:0] ops_ring_slot(input logic [3:0] wp, input logic [3:0] age);
    logic [4:0] s;
    s = {1'b0, wp} + DEPTH - 5'h01 - {1'b0, age};
    if (s >= DEPTH) begin
      s = s - DEPTH;
    end
    ops_ring_slot = s[3:0];
  endfunction

  // Write pointer and fill count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_q <= 4'h0;
      rec_count <= 4'h0;
    end else if (rec_wr) begin
      wp_q <= (wp_q == 4'(`OPS_RING_DEPTH - 1)) ? 4'h0 : wp_q + 4'h1;
      if (rec_count != 4'(`OPS_RING_DEPTH)) begin
        rec_count <= rec_count + 4'h1;
      end
    end
  end

  // Record storage
  always_ff @(posedge clk) begin
    if (rec_wr) begin
      stamp_m[wp_q] <= rec_stamp;
      event_m[wp_q] <= rec_event;
      pre_m[wp_q] <= rec_pre;
      fault_m[wp_q] <= rec_fault;
      prefault_m[wp_q] <= rec_prefault;
      remain_m[wp_q] <= rec_remain;
      group_m[wp_q] <= rec_group;
    end
  end

  // Read by age
  assign slot = ops_ring_slot(wp_q, rd_age);
  assign rd_stamp = stamp_m[slot];
  assign rd_event = event_m[slot];
  assign rd_pre = pre_m[slot];
  assign rd_fault = fault_m[slot];
  assign rd_prefault = prefault_m[slot];
  assign rd_remain = remain_m[slot];
  assign rd_group = group_m[slot];

endmodule

//--- ops_stage_sva.sv
// Checker of ops_stage_top outputs, bound below.
// Assumes CYCLE_CLKS of 8.
`timescale 1ns/1ps
module ops_stage_sva #(
  parameter int unsigned CYCLE_CLKS = 8
) (
  input logic clk,
  input logic sys_rst,
  input logic stage_forcing_enable,
  input logic [47:0] rtc_timestamp,
  input logic start_out,
  input logic trip_out,
  input logic blocked_out,
  input logic [1:0] condition,
  input logic event_valid,
  input logic [2:0] event_code,
  input logic [47:0] event_stamp
);
  // Stage outputs against condition and event stream
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_start_on; $rose(start_out); endsequence
  sequence s_start_ev; ##[1:4] event_valid && event_code == 3'h0; endsequence
  property p_excl; blocked_out |-> !start_out && !trip_out; endproperty
  a_excl: assert property (p_excl) else $error("blocked beside start or trip");
  property p_cond; trip_out && !stage_forcing_enable |=> stage_forcing_enable || condition == 2'h2; endproperty
  a_cond: assert property (p_cond) else $error("condition not trip");
  property p_blk; blocked_out && !stage_forcing_enable |=> stage_forcing_enable || condition == 2'h3; endproperty
  a_blk: assert property (p_blk) else $error("condition not blocked");
  property p_hold; $changed({start_out, trip_out, blocked_out}) |=> $stable({start_out, trip_out, blocked_out})[*7]; endproperty
  a_hold: assert property (p_hold) else $error("output moved between cycles");
  property p_ev; s_start_on |-> s_start_ev; endproperty
  a_ev: assert property (p_ev) else $error("no start event");
  property p_tev; $rose(trip_out) |-> ##[1:8] event_valid && event_code == 3'h2; endproperty
  a_tev: assert property (p_tev) else $error("no trip event");
  property p_code; event_valid |-> event_code <= 3'h5; endproperty
  a_code: assert property (p_code) else $error("bad event code");
  property p_stamp; event_valid |-> event_stamp == $past(rtc_timestamp); endproperty
  a_stamp: assert property (p_stamp) else $error("bad event stamp");
endmodule
bind ops_stage_top ops_stage_sva #(.CYCLE_CLKS(CYCLE_CLKS)) u_sva (.clk(clk), .sys_rst(sys_rst),
  .stage_forcing_enable(stage_forcing_enable), .rtc_timestamp(rtc_timestamp), .start_out(start_out),
  .trip_out(trip_out), .blocked_out(blocked_out), .condition(condition), .event_valid(event_valid),
  .event_code(event_code), .event_stamp(event_stamp));

//--- ops_meas_model.sv
// Measurement and blocking source in front of the stage.
// Assumes the bench sets wanted levels; outputs move after a clock edge.
`timescale 1ns/1ps
module ops_meas_model (
  input logic clk,
  input logic [31:0] power_req,
  input logic block_req,
  input logic [15:0] meas_req,
  output logic [31:0] power,
  output logic block_in,
  output logic [6:0][15:0] meas
);
  // Refresh every clock, channel i offset by i
  always @(posedge clk) begin
    power <= power_req;
    block_in <= block_req;
    for (int i = 0; i < 7; i++) meas[i] <= meas_req + 16'(i);
  end
endmodule

//--- testbench.sv
// Self-checking bench of ops_stage_top.
// Assumes CYCLE_CLKS of 8 clocks per cycle.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, forcing = 1'b0, blk_req = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, power_req = 32'h0, rd_v, p, power;
  logic [15:0] meas_req = 16'h0;
  logic [2:0] grp = 3'h0, event_code;
  logic [47:0] rtc = 48'h0, event_stamp;
  logic [6:0][15:0] meas;
  logic block_in, start_out, trip_out, blocked_out, event_valid;
  logic [1:0] condition;
  int n_fail = 0, num_checks = 0, cyc = 0, k;
  ops_meas_model u_meas (.clk(clk), .power_req(power_req), .block_req(blk_req), .meas_req(meas_req),
    .power(power), .block_in(block_in), .meas(meas));
  ops_stage_top #(.CYCLE_CLKS(8)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .measured_active_power(power), .phase_current_l1(meas[0]), .phase_current_l2(meas[1]),
    .phase_current_l3(meas[2]), .voltage_u1(meas[3]), .voltage_u2(meas[4]), .voltage_u3(meas[5]),
    .voltage_u4(meas[6]), .active_setting_group(grp), .block_in(block_in), .stage_forcing_enable(forcing),
    .rtc_timestamp(rtc), .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
    .condition(condition), .event_valid(event_valid), .event_code(event_code), .event_stamp(event_stamp));
  // Clock
  initial forever #25 clk = ~clk;
  // Time stamp source and run limit
  always @(posedge clk) begin
    rtc <= rtc + 48'h1;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  function automatic logic [31:0] f_ratio(input logic [31:0] pw, input logic [31:0] thr);
    return pw * 32'h64 / thr;
  endfunction
  function automatic logic [31:0] f_pick(input logic [31:0] pw, input logic [31:0] thr);
    return {31'h0, pw > thr};
  endfunction
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rd(a, rd_v);
    chk(nm, rd_v, exp);
  endtask
  task automatic pw(input logic [31:0] v, input logic b, input int n);
    @(posedge clk);
    power_req <= v;
    blk_req <= b;
    repeat (n * 8) @(posedge clk);
    @(negedge clk);
  endtask
  // Main sequence
  initial begin
    rd_v = $urandom(40453);
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rchk("pickup", 8'h80, 32'h2710);
    rchk("opdly", 8'h84, 32'h14);
    rchk("mask", 8'h08, 32'h3F);
    rd(8'hFC, rd_v);
    wr(8'h84, 32'h3);
    power_req <= 32'h2711;
    k = 0;
    while (start_out !== 1'b1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    chk("start", start_out, 32'h1);
    k = 0;
    while (trip_out !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("trip_dly", k, 32'h18);
    pw(32'h25E5, 1'b0, 2);
    chk("hyst_hold", trip_out, 32'h1);
    pw(32'h25E3, 1'b1, 2);
    chk("hyst_drop", trip_out, 32'h0);
    rchk("cnt_start", 8'h1C, 32'h1);
    rchk("ring_cnt", 8'h2C, 32'h2);
    wr(8'h04, 32'h7);
    rchk("cnt_clr", 8'h1C, 32'h0);
    pw(32'h2711, 1'b1, 2);
    chk("blocked", blocked_out, 32'h1);
    pw(32'h2711, 1'b1, 4);
    chk("blk_trip", trip_out, 32'h0);
    rchk("cnt_blk", 8'h24, 32'h1);
    pw(32'h0, 1'b0, 2);
    pw(32'h2711, 1'b0, 2);
    rchk("exp_time", 8'h14, 32'h3);
    pw(32'h2711, 1'b1, 4);
    chk("late_blk", start_out | trip_out, 32'h0);
    pw(32'h0, 1'b0, 2);
    wr(8'h90, 32'h4E20);
    grp <= 3'h1;
    pw(32'h3A98, 1'b0, 2);
    rchk("grp_ratio", 8'h10, f_ratio(32'h3A98, 32'h4E20));
    chk("grp_pick", start_out, 32'h0);
    grp <= 3'h0;
    for (int i = 0; i < 4; i++) begin
      p = 32'h251C + ($urandom % 32'h3E8);
      meas_req <= 16'($urandom);
      pw(p, 1'b0, 2);
      chk("pick", start_out, f_pick(p, 32'h2710));
      rchk("ratio", 8'h10, f_ratio(p, 32'h2710));
      rchk("meas", 8'h60 + 8'(4 * i), 32'(meas_req + 16'(i)));
      pw(32'h0, 1'b0, 2);
    end
    forcing <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h00, 32'(c));
      repeat (3) @(negedge clk);
      chk("forced", condition, 32'(c));
    end
    print_verdict();
  end
endmodule
